// ---- sba_params.svh ----
// constants for the system bus arbitration and configuration block
// assumes inclusion by bare name from the design module
`ifndef SBA_PARAMS_SVH
`define SBA_PARAMS_SVH

`define SBA_STRAP_DEFAULT   1'h1
`define SBA_CPU_ADDR_LSB    3
`define SBA_CPU_ADDR_MSB    19
`define SBA_RAM_AW          17
`define SBA_WORD_BITS       3
`define SBA_WRAP_MASK_32B   3'h3
`define SBA_WRAP_MASK_64B   3'h7
`define SBA_BEAT_LAST_32B   3'h3
`define SBA_BEAT_LAST_64B   3'h7
`define SBA_BEAT_LAST_ONE   3'h0
`define SBA_ALL_LANES       8'hFF
`define SBA_NO_LANES        8'h00
`define SBA_SIZE_256K       2'h3
`define SBA_SIZE_1M         2'h1

`endif

// ---- sba_pkg.sv ----
// types shared by the system bus arbitration and configuration block
// assumes sba_params.svh is on the include path
package sba_pkg;

    typedef enum logic [2:0] {
        SYS_FILL,
        SYS_CI_READ,
        SYS_COPYBACK,
        SYS_WRITE_THRU,
        SYS_CI_WRITE
    } sba_sys_kind_t;

    typedef enum logic [1:0] {
        A_IDLE,
        A_REQ,
        A_OWN
    } sba_astate_t;

    typedef enum logic [1:0] {
        D_IDLE,
        D_ARB,
        D_OWN
    } sba_dstate_t;

    typedef enum logic [1:0] {
        SIZE_256K,
        SIZE_1M,
        SIZE_RESERVED
    } sba_size_t;

endpackage : sba_pkg

// ---- sba_arbiter.sv ----
// system bus arbitration, cache ram control and strap configuration
// assumes synchronous inputs other than arst_n, all levels active high except arst_n, two-way pins resolved outside
//
// Functional notes
// - keep address request up until qualified grant or request withdrawn
// - take address bus only on grant with address busy negated
// - when parked with grant held, start at once without requesting
// - drive address busy only while address master, else sample it
// - transfer start requests data bus; take it on grant with busy negated
// - sample data busy while arbitrating, drive while master, float otherwise
// - cache ram address follows processor address one clock later
// - advance ram address during bursts one clock before each beat
// - one write enable per byte lane, only lanes being written
// - processor write enables cpu-to-ram, processor read enables ram-to-cpu
// - fills and inhibited reads enable bus-to-ram, write-outs ram-to-bus
// - after reset strap pins show tag function bits 0-1 and tag status, delayed one clock
// - select when chip select matches the latched polarity strap
// - full speed when half-rate clock held high, else its leading edge
// - suspend during reset, latch straps at release, then operate
// - line length strap high gives 32-byte line, low 64-byte
// - burst order strap high gives critical word first, low zero first
// - arbiter strap high gives on-chip arbitration, low external
// - size straps: 11 is 256K, 01 is 1M, others reserved
// - weak default drive on straps in reset, tag monitor afterwards
// - transfer start is one clock at transaction begin only
// - address acknowledge ends address tenure and releases busy
`timescale 1ns/1ns
`include "sba_params.svh"

module sba_arbiter (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic                  clk_en,
    input  wire logic                  hclk,
    input  wire logic                  chip_sel,
    output logic                       chip_selected,
    input  wire logic                  xact_req,
    input  wire logic                  xact_cancel,
    input  wire sba_pkg::sba_sys_kind_t xact_kind,
    input  wire logic                  xact_burst,
    input  wire logic [16:0]           xact_ram_addr,
    output logic                       sys_addr_req,
    input  wire logic                  sys_addr_grant,
    input  wire logic                  sys_addr_busy_in,
    output logic                       sys_addr_busy_out,
    output logic                       sys_addr_busy_oe,
    output logic                       sys_addr_drive_en,
    input  wire logic                  sys_address_ack,
    output logic                       sys_xfer_start_out,
    output logic                       sys_xfer_start_oe,
    input  wire logic                  sys_data_grant,
    input  wire logic                  sys_data_busy_in,
    output logic                       sys_data_busy_out,
    output logic                       sys_data_busy_oe,
    input  wire logic                  sys_xfer_ack,
    input  wire logic                  cpu_addr_valid,
    input  wire logic [31:0]           cpu_addr,
    input  wire logic                  cpu_data_phase,
    input  wire logic                  cpu_write,
    input  wire logic [7:0]            cpu_byte_mask,
    output logic [16:0]                cache_ram_addr,
    output logic [7:0]                 cache_byte_write_en,
    output logic                       cpu_to_ram_drive_en,
    output logic                       ram_to_cpu_drive_en,
    output logic                       bus_to_ram_drive_en,
    output logic                       ram_to_bus_drive_en,
    input  wire logic [2:0]            tag_func,
    input  wire logic [3:0]            tag_status,
    input  wire logic                  line_length_strap_in,
    output logic                       line_length_strap_out,
    output logic                       line_length_strap_oe,
    input  wire logic                  burst_order_strap_in,
    output logic                       burst_order_strap_out,
    output logic                       burst_order_strap_oe,
    output logic                       tag_function_bit2_out,
    output logic                       tag_function_bit2_oe,
    input  wire logic                  select_polarity_strap_in,
    output logic                       select_polarity_strap_out,
    output logic                       select_polarity_strap_oe,
    input  wire logic                  arbiter_choice_strap_in,
    output logic                       arbiter_choice_strap_out,
    output logic                       arbiter_choice_strap_oe,
    input  wire logic                  size_strap_low_in,
    output logic                       size_strap_low_out,
    output logic                       size_strap_low_oe,
    input  wire logic                  size_strap_high_in,
    output logic                       size_strap_high_out,
    output logic                       size_strap_high_oe,
    output logic                       strap_weak_pull,
    output logic                       cfg_line_64,
    output logic                       cfg_zero_first,
    output logic                       cfg_ext_arb,
    output sba_pkg::sba_size_t         cfg_size
);
    import sba_pkg::*;

    function automatic logic is_bus_in(input sba_sys_kind_t k);
        is_bus_in = (k == SYS_FILL) || (k == SYS_CI_READ);
    endfunction : is_bus_in

    function automatic logic is_bus_out(input sba_sys_kind_t k);
        is_bus_out = (k == SYS_COPYBACK) || (k == SYS_WRITE_THRU) || (k == SYS_CI_WRITE);
    endfunction : is_bus_out

    logic          cfg_taken_reg;
    logic          cfg_line32_reg;
    logic          cfg_cwf_reg;
    logic          cfg_sel_pol_reg;
    logic          cfg_onchip_arb_reg;
    logic [1:0]    cfg_size_reg;
    logic [2:0]    tag_func_reg;
    logic [3:0]    tag_status_reg;
    sba_astate_t   astate_reg;
    sba_dstate_t   dstate_reg;
    sba_dstate_t   dstate_next;
    sba_sys_kind_t kind_reg;
    logic          burst_reg;
    logic          start_reg;
    logic [2:0]    beat_reg;
    logic [2:0]    beat_last;
    logic [2:0]    wrap_mask;
    logic [16:0]   ram_addr_reg;
    logic [7:0]    we_reg;
    logic          c2r_reg;
    logic          r2c_reg;
    logic          b2r_reg;
    logic          r2b_reg;
    logic          run;
    logic          qual_grant;
    logic          take_addr;
    logic          cpu_load;
    logic          beat_ack;

    // bus clock tick: hclk held high gives every edge, else one per hclk period
    assign run        = clk_en & hclk & cfg_taken_reg;
    assign qual_grant = sys_addr_grant & ~sys_addr_busy_in;
    assign wrap_mask  = cfg_line32_reg ? `SBA_WRAP_MASK_32B : `SBA_WRAP_MASK_64B;
    assign beat_last  = !burst_reg      ? `SBA_BEAT_LAST_ONE :
                        cfg_line32_reg  ? `SBA_BEAT_LAST_32B : `SBA_BEAT_LAST_64B;
    assign beat_ack   = run && dstate_reg == D_OWN && sys_xfer_ack;

    // straps caught once, on the first enabled edge after release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_taken_reg      <= 1'h0;
            cfg_line32_reg     <= `SBA_STRAP_DEFAULT;
            cfg_cwf_reg        <= `SBA_STRAP_DEFAULT;
            cfg_sel_pol_reg    <= `SBA_STRAP_DEFAULT;
            cfg_onchip_arb_reg <= `SBA_STRAP_DEFAULT;
            cfg_size_reg       <= `SBA_SIZE_256K;
        end else if (clk_en && !cfg_taken_reg) begin
            cfg_taken_reg      <= 1'h1;
            cfg_line32_reg     <= line_length_strap_in;
            cfg_cwf_reg        <= burst_order_strap_in;
            cfg_sel_pol_reg    <= select_polarity_strap_in;
            cfg_onchip_arb_reg <= arbiter_choice_strap_in;
            cfg_size_reg       <= {size_strap_high_in, size_strap_low_in};
        end
    end

    assign cfg_line_64    = ~cfg_line32_reg;
    assign cfg_zero_first = ~cfg_cwf_reg;
    assign cfg_ext_arb    = ~cfg_onchip_arb_reg;
    assign chip_selected  = cfg_taken_reg & (chip_sel == cfg_sel_pol_reg);

    always_comb begin
        unique case (cfg_size_reg)
            `SBA_SIZE_256K: cfg_size = SIZE_256K;
            `SBA_SIZE_1M:   cfg_size = SIZE_1M;
            default:        cfg_size = SIZE_RESERVED;
        endcase
    end

    // tag monitor: one clock behind the state it reports
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tag_func_reg   <= 3'h0;
            tag_status_reg <= 4'h0;
        end else if (clk_en) begin
            tag_func_reg   <= tag_func;
            tag_status_reg <= tag_status;
        end
    end

    // during reset the pins are floated and only the weak default holds them
    assign strap_weak_pull           = ~cfg_taken_reg;
    assign line_length_strap_oe      = cfg_taken_reg;
    assign burst_order_strap_oe      = cfg_taken_reg;
    assign tag_function_bit2_oe      = cfg_taken_reg;
    assign select_polarity_strap_oe  = cfg_taken_reg;
    assign arbiter_choice_strap_oe   = cfg_taken_reg;
    assign size_strap_low_oe         = cfg_taken_reg;
    assign size_strap_high_oe        = cfg_taken_reg;
    assign line_length_strap_out     = tag_func_reg[0];
    assign burst_order_strap_out     = tag_func_reg[1];
    assign tag_function_bit2_out     = tag_func_reg[2];
    assign select_polarity_strap_out = tag_status_reg[0];
    assign arbiter_choice_strap_out  = tag_status_reg[1];
    assign size_strap_low_out        = tag_status_reg[2];
    assign size_strap_high_out       = tag_status_reg[3];

    // address tenure
    assign take_addr = run && qual_grant &&
                       ((astate_reg == A_IDLE && xact_req) ||
                        (astate_reg == A_REQ && !xact_cancel));

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            astate_reg <= A_IDLE;
        end else if (run) begin
            unique case (astate_reg)
                A_IDLE: begin
                    if (xact_req) begin
                        astate_reg <= qual_grant ? A_OWN : A_REQ;
                    end
                end
                A_REQ: begin
                    if (xact_cancel) begin
                        astate_reg <= A_IDLE;
                    end else if (qual_grant) begin
                        astate_reg <= A_OWN;
                    end
                end
                A_OWN: begin
                    if (sys_address_ack) begin
                        astate_reg <= A_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_reg <= 1'h0;
            kind_reg  <= SYS_FILL;
            burst_reg <= 1'h0;
        end else if (run) begin
            start_reg <= take_addr;
            if (take_addr) begin
                kind_reg  <= xact_kind;
                burst_reg <= xact_burst;
            end
        end
    end

    assign sys_addr_req       = astate_reg == A_REQ;
    assign sys_addr_busy_out  = 1'h1;
    assign sys_addr_busy_oe   = astate_reg == A_OWN;
    assign sys_addr_drive_en  = astate_reg == A_OWN;
    assign sys_xfer_start_out = start_reg;
    assign sys_xfer_start_oe  = astate_reg == A_OWN;

    // data tenure, requested by the transfer start pulse
    always_comb begin
        dstate_next = dstate_reg;
        unique case (dstate_reg)
            D_IDLE: begin
                if (start_reg) begin
                    dstate_next = D_ARB;
                end
            end
            D_ARB: begin
                if (sys_data_grant && !sys_data_busy_in) begin
                    dstate_next = D_OWN;
                end
            end
            D_OWN: begin
                if (sys_xfer_ack && beat_reg == beat_last) begin
                    dstate_next = D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dstate_reg <= D_IDLE;
            beat_reg   <= 3'h0;
        end else if (run) begin
            dstate_reg <= dstate_next;
            if (dstate_reg != D_OWN) begin
                beat_reg <= 3'h0;
            end else if (sys_xfer_ack) begin
                beat_reg <= beat_reg + 3'h1;
            end
        end
    end

    assign sys_data_busy_out = 1'h1;
    assign sys_data_busy_oe  = dstate_reg == D_OWN;

    // ram address: processor side only while the data tenure is idle and no address is being taken
    assign cpu_load = run && cpu_addr_valid && dstate_reg == D_IDLE && !take_addr;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_addr_reg <= 17'h0;
        end else if (run) begin
            if (take_addr) begin
                ram_addr_reg <= cfg_cwf_reg ? xact_ram_addr :
                                {xact_ram_addr[16:`SBA_WORD_BITS], 3'h0};
            end else if (beat_ack) begin
                // wrap inside the line so critical-word-first ends where it began
                ram_addr_reg[2:0] <= ((ram_addr_reg[2:0] + 3'h1) & wrap_mask) |
                                     (ram_addr_reg[2:0] & ~wrap_mask);
            end else if (cpu_load) begin
                ram_addr_reg <= cpu_addr[`SBA_CPU_ADDR_MSB:`SBA_CPU_ADDR_LSB];
            end
        end
    end

    assign cache_ram_addr = ram_addr_reg;

    // byte lanes and data path steering
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            we_reg <= `SBA_NO_LANES;
        end else if (run) begin
            if (beat_ack && kind_reg == SYS_FILL) begin
                we_reg <= `SBA_ALL_LANES;
            end else if (dstate_reg != D_OWN && cpu_data_phase && cpu_write) begin
                we_reg <= cpu_byte_mask;
            end else begin
                we_reg <= `SBA_NO_LANES;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            c2r_reg <= 1'h0;
            r2c_reg <= 1'h0;
            b2r_reg <= 1'h0;
            r2b_reg <= 1'h0;
        end else if (run) begin
            c2r_reg <= cpu_data_phase && cpu_write;
            r2c_reg <= cpu_data_phase && !cpu_write;
            b2r_reg <= dstate_next == D_OWN && is_bus_in(kind_reg);
            r2b_reg <= dstate_next == D_OWN && is_bus_out(kind_reg);
        end
    end

    assign cache_byte_write_en = we_reg;
    assign cpu_to_ram_drive_en = c2r_reg;
    assign ram_to_cpu_drive_en = r2c_reg;
    assign bus_to_ram_drive_en = b2r_reg;
    assign ram_to_bus_drive_en = r2b_reg;

    a_req_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (run && astate_reg == A_REQ && !qual_grant && !xact_cancel) |=> sys_addr_req)
        else $error("address request dropped without grant");

    a_own_qualified: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(sys_addr_busy_oe) |-> $past(sys_addr_grant && !sys_addr_busy_in))
        else $error("address bus taken without qualified grant");

    a_park_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (run && astate_reg == A_IDLE && xact_req && qual_grant) |=>
        (sys_addr_busy_oe && !sys_addr_req && sys_xfer_start_out))
        else $error("parked start did not begin at once");

    a_start_once: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (sys_xfer_start_out && run) |=> !sys_xfer_start_out)
        else $error("transfer start longer than one bus clock");

    a_aack_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (run && sys_addr_busy_oe && sys_address_ack) |=> !sys_addr_busy_oe && !sys_addr_drive_en)
        else $error("address tenure not ended on acknowledge");

    a_data_qualified: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(sys_data_busy_oe) |-> $past(sys_data_grant && !sys_data_busy_in && run))
        else $error("data bus taken without qualified grant");

    a_dbb_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (beat_ack && beat_reg == beat_last) |=> !sys_data_busy_oe)
        else $error("data busy still driven after the last beat");

    a_cpu_ram_addr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cpu_load |=> cache_ram_addr == $past(cpu_addr[`SBA_CPU_ADDR_MSB:`SBA_CPU_ADDR_LSB]))
        else $error("ram address not one clock after processor address");

    a_burst_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
        beat_ack |=> (cache_ram_addr[16:3] == $past(cache_ram_addr[16:3]) &&
                      cache_ram_addr != $past(cache_ram_addr)))
        else $error("burst address did not advance within the line");

    a_tag_delay: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cfg_taken_reg && clk_en) |=> (size_strap_high_out == $past(tag_status[3]) &&
                                       line_length_strap_out == $past(tag_func[0])))
        else $error("tag monitor not one clock behind");

    a_cfg_stable: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg_taken_reg |=> ($stable(cfg_size_reg) && $stable(cfg_line32_reg) &&
                           $stable(cfg_sel_pol_reg) && $stable(cfg_cwf_reg)))
        else $error("configuration changed after capture");

endmodule : sba_arbiter

// ---- sba_bus_partner.sv ----
// far side of the system bus: address arbiter, data arbiter and memory
// assumes active-high levels at the block's ports and one shared clock
`timescale 1ns/1ns
module sba_bus_partner (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic park,
    input  wire logic sys_addr_req,
    input  wire logic sys_xfer_start_out,
    input  wire logic sys_xfer_start_oe,
    input  wire logic sys_data_busy_oe,
    output logic      sys_addr_grant,
    output logic      sys_address_ack,
    output logic      sys_data_grant,
    output logic      sys_xfer_ack
);
    logic [1:0] wait_cnt;
    logic       start_seen;

    assign start_seen = sys_xfer_start_out & sys_xfer_start_oe;

    // slow grant after four request cycles; parking holds it while idle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt       <= 2'h0;
            sys_addr_grant <= 1'h0;
        end else begin
            wait_cnt       <= !sys_addr_req ? 2'h0 : (wait_cnt == 2'h3) ? 2'h3 : wait_cnt + 2'h1;
            sys_addr_grant <= park | (sys_addr_req & (wait_cnt == 2'h3));
        end
    end

    // ack trails ownership by a clock, so it leads each data beat
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sys_address_ack <= 1'h0;
            sys_data_grant  <= 1'h0;
            sys_xfer_ack    <= 1'h0;
        end else begin
            sys_address_ack <= start_seen;
            sys_data_grant  <= start_seen | (sys_data_grant & !sys_data_busy_oe);
            sys_xfer_ack    <= sys_data_busy_oe;
        end
    end
endmodule : sba_bus_partner

// ---- sba_arbiter_tb.sv ----
// bench for sba_arbiter: straps, tag pins, arbitration and ram control
// assumes sba_bus_partner on the far side; strap pins pulled up here
`timescale 1ns/1ns
module sba_arbiter_tb;
    import sba_pkg::*;

    logic ref_clk, arst_n, clk_en, hclk, chip_sel, chip_selected, xact_req, xact_cancel;
    logic xact_burst, sys_addr_req, sys_addr_grant, sys_addr_busy_in, sys_addr_busy_out;
    logic sys_addr_busy_oe, sys_addr_drive_en, sys_address_ack, sys_xfer_start_out;
    logic sys_xfer_start_oe, sys_data_grant, sys_data_busy_in, sys_data_busy_out;
    logic sys_data_busy_oe, sys_xfer_ack, cpu_addr_valid, cpu_data_phase, cpu_write;
    logic cpu_to_ram_drive_en, ram_to_cpu_drive_en, bus_to_ram_drive_en, ram_to_bus_drive_en;
    logic tag_function_bit2_out, tag_function_bit2_oe, strap_weak_pull, cfg_line_64;
    logic cfg_zero_first, cfg_ext_arb, park, other_abb, s_drv;
    logic [16:0]   xact_ram_addr, cache_ram_addr;
    logic [31:0]   cpu_addr;
    logic [7:0]    cpu_byte_mask, cache_byte_write_en;
    logic [2:0]    tag_func;
    logic [3:0]    tag_status;
    logic [5:0]    s_in, s_out, s_oe, s_val;
    sba_sys_kind_t xact_kind;
    sba_size_t     cfg_size;
    int            err_count, checked;
    logic [5:0]    strap_sets [3] = '{6'h3F, 6'h10, 6'h2A};

    assign s_in = (s_oe & s_out) | (~s_oe & (s_drv ? s_val : 6'h3F));
    assign sys_addr_busy_in = other_abb | (sys_addr_busy_oe & sys_addr_busy_out);
    assign sys_data_busy_in = sys_data_busy_oe & sys_data_busy_out;

    sba_arbiter i_dut (.*,
        .line_length_strap_in(s_in[0]), .line_length_strap_out(s_out[0]),
        .line_length_strap_oe(s_oe[0]), .burst_order_strap_in(s_in[1]),
        .burst_order_strap_out(s_out[1]), .burst_order_strap_oe(s_oe[1]),
        .select_polarity_strap_in(s_in[2]), .select_polarity_strap_out(s_out[2]),
        .select_polarity_strap_oe(s_oe[2]), .arbiter_choice_strap_in(s_in[3]),
        .arbiter_choice_strap_out(s_out[3]), .arbiter_choice_strap_oe(s_oe[3]),
        .size_strap_low_in(s_in[4]), .size_strap_low_out(s_out[4]),
        .size_strap_low_oe(s_oe[4]), .size_strap_high_in(s_in[5]),
        .size_strap_high_out(s_out[5]), .size_strap_high_oe(s_oe[5]));
    sba_bus_partner i_far (.*);

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset(input logic [5:0] val, input logic drv);
        {arst_n, s_val, s_drv} = {1'h0, val, drv};
        repeat (20) @(negedge ref_clk);
        check("reset pins", {strap_weak_pull, s_oe, sys_addr_req}, 8'h80);
        arst_n = 1'h1;
        repeat (2) @(negedge ref_clk);
        s_drv = 1'h0;
    endtask : do_reset

    task automatic cpu(input logic wr);
        @(negedge ref_clk);
        cpu_addr_valid = 1'h1;
        @(negedge ref_clk);
        cpu_addr_valid = 1'h0;
        check("ram addr", cache_ram_addr, 17'h1579B);
        {cpu_data_phase, cpu_write, cpu_byte_mask} = {1'h1, wr, 8'h3C};
        @(negedge ref_clk);
        cpu_data_phase = 1'h0;
        check("cpu path", {cpu_to_ram_drive_en, ram_to_cpu_drive_en}, {wr, !wr});
        check("cpu lanes", cache_byte_write_en, wr ? 8'h3C : 8'h00);
    endtask : cpu

    task automatic xact(input sba_sys_kind_t kind, input logic burst, input logic pk,
                        input logic l64);
        int n, tenure, acks;
        logic prev, own;
        logic [3:0] seen;
        park = pk;
        @(negedge ref_clk);
        xact_kind = kind;
        {xact_burst, xact_req, other_abb} = {burst, 1'h1, !pk};
        for (n = 0; !sys_addr_busy_oe && n < 30; n++) begin
            @(negedge ref_clk);
            if (other_abb) check("held req", {sys_addr_req, sys_addr_busy_oe}, 2'h2);
            if (n == 6) other_abb = 1'h0;
        end
        xact_req = 1'h0;
        check("take", {sys_addr_req, sys_xfer_start_out, sys_xfer_start_oe,
                       sys_addr_drive_en}, 4'h7);
        {tenure, acks, seen, prev, own} = {32'h1, 32'h0, 4'h0, 2'h0};
        for (n = 0; n < 40; n++) begin
            @(negedge ref_clk);
            if (n == 0) check("start pulse", sys_xfer_start_out, 1'h0);
            if (prev) begin
                seen[cache_ram_addr[1:0]] = 1'h1;
                check("upper ram addr", cache_ram_addr[16:3], 14'h3578);
                check("lanes", cache_byte_write_en, (kind == SYS_FILL) ? 8'hFF : 8'h00);
            end
            if (sys_data_busy_oe) check("data path", {bus_to_ram_drive_en, ram_to_bus_drive_en},
                                        (kind < SYS_COPYBACK) ? 2'h2 : 2'h1);
            tenure += sys_addr_busy_oe;
            acks += sys_data_busy_oe & sys_xfer_ack;
            prev = sys_data_busy_oe & sys_xfer_ack;
            own |= sys_data_busy_oe;
            if (own && !sys_data_busy_oe) break;
        end
        check("address tenure", tenure, 17'h2);
        check("beats", acks, burst ? (l64 ? 17'h8 : 17'h4) : 17'h1);
        if (burst) check("wrap", seen, 4'hF);
    endtask : xact

    initial begin
        {arst_n, xact_req, xact_cancel, xact_burst, park, other_abb, s_drv} = 7'h0;
        {clk_en, hclk, chip_sel} = 3'h7;
        {cpu_addr_valid, cpu_data_phase, cpu_write, cpu_byte_mask, tag_func, tag_status} = 18'h0;
        {cpu_addr, xact_ram_addr, s_val} = {32'h000ABCD8, 17'h1ABC5, 6'h3F};
        xact_kind = SYS_FILL;
        {err_count, checked} = 64'h0;
        for (int i = 0; i < 3; i++) begin
            do_reset(strap_sets[i], i != 0);
            {tag_func, tag_status} = {3'h5, 4'hA};
            @(negedge ref_clk);
            check("tag pins", {s_oe, tag_function_bit2_oe, s_out, tag_function_bit2_out},
                  14'h3FD3);
            {tag_func, tag_status} = {3'h2, 4'h5};
            @(negedge ref_clk);
            check("line 64", cfg_line_64, !strap_sets[i][0]);
            check("zero first", cfg_zero_first, !strap_sets[i][1]);
            check("ext arb", cfg_ext_arb, !strap_sets[i][3]);
            check("size", cfg_size, (strap_sets[i][5:4] == 2'h3) ? SIZE_256K :
                  (strap_sets[i][5:4] == 2'h1) ? SIZE_1M : SIZE_RESERVED);
            chip_sel = !strap_sets[i][2];
            @(negedge ref_clk);
            check("unselected", chip_selected, 1'h0);
            chip_sel = strap_sets[i][2];
            @(negedge ref_clk);
            check("selected", chip_selected, 1'h1);
            if (i == 0) begin
                // parked grant is there, but no tick may take it
                {park, hclk, xact_req} = 3'h5;
                repeat (3) @(negedge ref_clk);
                check("stalled", sys_addr_busy_oe, 1'h0);
                park = 1'h0;
                @(negedge ref_clk);
                hclk = 1'h1;
                @(negedge ref_clk);
                check("requesting", sys_addr_req, 1'h1);
                xact_cancel = 1'h1;
                @(negedge ref_clk);
                check("withdrawn", {sys_addr_req, sys_addr_busy_oe}, 2'h0);
                {xact_cancel, xact_req} = 2'h0;
            end
            for (int k = 0; k < 5; k++) begin
                xact(sba_sys_kind_t'(k), k == 0 || k == 2, k % 2 == 0, !strap_sets[i][0]);
            end
            cpu(1'h1);
            cpu(1'h0);
        end
        give_verdict();
    end

    // whole run is a few hundred clocks; this span of 4000 clocks is over ten times that
    initial begin
        #200_000;
        err_count++;
        give_verdict();
    end
endmodule : sba_arbiter_tb
